// ### td_retry_pkg.sv
package td_retry_pkg;
   // descriptor control/status word layout
   localparam int SHORT_DET   = 29;
   localparam int CERR_HI     = 28;
   localparam int CERR_LO     = 27;
   localparam int ACTIVE_BIT  = 23;
   localparam int STALL_BIT   = 22;
   localparam int DBUF_BIT    = 21;
   localparam int BABBLE_BIT  = 20;
   localparam int CRCTO_BIT   = 18;
   localparam int BSTUFF_BIT  = 17;

   localparam logic [1:0] CERR_NO_LIMIT = 2'h0;
   localparam logic [1:0] CERR_LAST     = 2'h1;

   // register byte addresses
   localparam logic [3:0] STATUS_ADDR = 4'h0;
   localparam logic [3:0] MASK_ADDR   = 4'h4;
   localparam logic [3:0] CTRL_ADDR   = 4'h8;
   localparam logic [3:0] LASTWB_ADDR = 4'hc;

   // status / mask bit positions
   localparam int ST_SHORT = 0;
   localparam int ST_ERRLIM = 1;
   localparam int ST_W = 2;

   // ctrl bit positions
   localparam int CTRL_CRC_EN = 0;
   localparam int CTRL_TO_EN  = 1;
   localparam int CTRL_W      = 2;

   localparam logic [ST_W-1:0]   STATUS_RESET = 2'h0;
   localparam logic [ST_W-1:0]   MASK_RESET   = 2'h0;
   localparam logic [CTRL_W-1:0] CTRL_RESET   = 2'h0;
   localparam logic [31:0]       WORD_RESET   = 32'h0;
endpackage

// ### td_retry.sv
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - enabled short packet on a queued input success marks descriptor inactive
// - short packet keeps queue head and sets transfer interrupt status at frame end
// - short packet interrupt reaches the line only when its mask enables it
// - any transaction error suppresses short packet reporting
// - two-bit error down counter lives in descriptor bits 28 to 27
// - nonzero counter decrements on a crc, timeout, buffer or bit stuff error and is written back
// - decrement from one to zero deactivates, sets stalled and causing error bit
// - limit hit by buffer or bit stuff error interrupts; crc, timeout if enabled
// - counter set to zero means errors are not counted, unlimited retries
// - initial counter 01, 10, 11 allows one, two, three errors
module td_retry #(
   parameter int ADDR_W = 4
) (
   input  wire logic              I_CLK_SYS,
   input  wire logic              I_RESETN,
   // apb slave
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]       I_PWDATA,
   output logic                   O_PREADY,
   output logic                   O_PSLVERR,
   output logic [31:0]            O_PRDATA,
   // transaction result from the engine
   input  wire logic              I_TXN_DONE,
   input  wire logic [31:0]       I_TD_WORD,
   input  wire logic              I_TXN_IN,
   input  wire logic              I_TXN_QUEUED,
   input  wire logic              I_TXN_SHORT,
   input  wire logic              I_ERR_CRC,
   input  wire logic              I_ERR_TIMEOUT,
   input  wire logic              I_ERR_BABBLE,
   input  wire logic              I_ERR_STALL,
   input  wire logic              I_ERR_DBUF,
   input  wire logic              I_ERR_BSTUFF,
   input  wire logic              I_FRAME_END,
   // write-back to memory and queue-head path
   output logic                   O_WB_VALID,
   output logic [31:0]            O_WB_WORD,
   output logic                   O_QH_KEEP,
   output logic                   O_XFER_INT_STATUS,
   output logic                   O_IRQ
);

   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W must be at least 4");
   end

   logic [1:0]  cerr;
   logic        any_err;
   logic        count_err;
   logic        short_hit;
   logic        dec;
   logic        to_zero;
   logic        irq_err;
   logic        deactivate;
   logic [1:0]  next_cerr;
   logic [31:0] next_word;

   logic [td_retry_pkg::ST_W-1:0]   status;
   logic [td_retry_pkg::ST_W-1:0]   mask;
   logic [td_retry_pkg::ST_W-1:0]   next_mask;
   logic [td_retry_pkg::CTRL_W-1:0] ctrl;
   logic [31:0]                     last_wb;
   logic                            pend_short;
   logic                            pend_err;

   assign cerr = I_TD_WORD[td_retry_pkg::CERR_HI:td_retry_pkg::CERR_LO];
   assign any_err = I_ERR_CRC | I_ERR_TIMEOUT | I_ERR_BABBLE | I_ERR_STALL
                  | I_ERR_DBUF | I_ERR_BSTUFF;
   // babble and stall deactivate directly, so they never consume a retry
   assign count_err = I_ERR_CRC | I_ERR_TIMEOUT | I_ERR_DBUF | I_ERR_BSTUFF;
   assign short_hit = I_TXN_DONE & I_TD_WORD[td_retry_pkg::SHORT_DET] & I_TXN_IN
                    & I_TXN_QUEUED & I_TXN_SHORT & ~any_err;
   assign dec = I_TXN_DONE & count_err & (cerr != td_retry_pkg::CERR_NO_LIMIT);
   assign to_zero = dec & (cerr == td_retry_pkg::CERR_LAST);
   assign irq_err = to_zero & (I_ERR_DBUF | I_ERR_BSTUFF
                  | (I_ERR_CRC & ctrl[td_retry_pkg::CTRL_CRC_EN])
                  | (I_ERR_TIMEOUT & ctrl[td_retry_pkg::CTRL_TO_EN]));
   assign deactivate = short_hit | to_zero | (I_TXN_DONE & (I_ERR_BABBLE | I_ERR_STALL));
   assign next_cerr = dec ? cerr - 2'h1 : cerr;

   always_comb begin
      next_word = I_TD_WORD;
      next_word[td_retry_pkg::CERR_HI:td_retry_pkg::CERR_LO] = next_cerr;
      if (deactivate) begin
         next_word[td_retry_pkg::ACTIVE_BIT] = 1'b0;
      end
      if (to_zero) begin
         next_word[td_retry_pkg::STALL_BIT]  = 1'b1;
         next_word[td_retry_pkg::DBUF_BIT]   = I_TD_WORD[td_retry_pkg::DBUF_BIT] | I_ERR_DBUF;
         next_word[td_retry_pkg::CRCTO_BIT]  = I_TD_WORD[td_retry_pkg::CRCTO_BIT]
                                             | I_ERR_CRC | I_ERR_TIMEOUT;
         next_word[td_retry_pkg::BSTUFF_BIT] = I_TD_WORD[td_retry_pkg::BSTUFF_BIT]
                                             | I_ERR_BSTUFF;
      end
      if (I_ERR_BABBLE) begin
         next_word[td_retry_pkg::BABBLE_BIT] = 1'b1;
         next_word[td_retry_pkg::STALL_BIT]  = 1'b1;
      end
      if (I_ERR_STALL) begin
         next_word[td_retry_pkg::STALL_BIT] = 1'b1;
      end
   end

   // write-back path
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_WB_VALID <= 1'b0;
         O_WB_WORD  <= td_retry_pkg::WORD_RESET;
         O_QH_KEEP  <= 1'b0;
         last_wb    <= td_retry_pkg::WORD_RESET;
      end else begin
         O_WB_VALID <= I_TXN_DONE;
         O_QH_KEEP  <= short_hit;
         if (I_TXN_DONE) begin
            O_WB_WORD <= next_word;
            last_wb   <= next_word;
         end
      end
   end

   // apb decode
   logic        setup;
   logic        access;
   logic        hit_status;
   logic        hit_mask;
   logic        hit_ctrl;
   logic        hit_lastwb;
   logic        mapped;
   logic        wr_en;
   logic        rd_status;
   logic [31:0] rd_mux;
   logic [3:0]  word_addr;
   logic        upper_zero;

   // a narrow bus has no upper bits to decode
   if (ADDR_W > 4) begin : g_upper
      assign upper_zero = ~|I_PADDR[ADDR_W-1:4];
   end else begin : g_no_upper
      assign upper_zero = 1'b1;
   end

   assign word_addr  = I_PADDR[3:0];
   assign setup      = I_PSEL & ~I_PENABLE;
   assign access     = I_PSEL & I_PENABLE & O_PREADY;
   assign hit_status = (word_addr == td_retry_pkg::STATUS_ADDR);
   assign hit_mask   = (word_addr == td_retry_pkg::MASK_ADDR);
   assign hit_ctrl   = (word_addr == td_retry_pkg::CTRL_ADDR);
   assign hit_lastwb = (word_addr == td_retry_pkg::LASTWB_ADDR);
   assign mapped     = upper_zero &
                       (hit_status | hit_mask | hit_ctrl | hit_lastwb);
   assign wr_en      = access & I_PWRITE & mapped;
   assign rd_status  = access & ~I_PWRITE & mapped & hit_status;
   assign rd_mux     = ~mapped   ? 32'h0 :
                       hit_status ? {30'h0, status} :
                       hit_mask   ? {30'h0, mask} :
                       hit_ctrl   ? {30'h0, ctrl} :
                       last_wb;

   // one wait-free access phase: read data is captured in setup, write data in access
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0;
      end else begin
         O_PREADY  <= setup;
         O_PSLVERR <= setup & ~mapped;
         O_PRDATA  <= (setup & ~I_PWRITE) ? rd_mux : 32'h0;
      end
   end

   // the interrupt line follows a mask write at the same edge
   assign next_mask = (wr_en & hit_mask) ? I_PWDATA[td_retry_pkg::ST_W-1:0] : mask;

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         mask <= td_retry_pkg::MASK_RESET;
         ctrl <= td_retry_pkg::CTRL_RESET;
      end else begin
         mask <= next_mask;
         if (wr_en & hit_ctrl) begin
            ctrl <= I_PWDATA[td_retry_pkg::CTRL_W-1:0];
         end
      end
   end

   // events wait for the frame boundary before becoming visible
   logic [td_retry_pkg::ST_W-1:0] st_set;
   logic [td_retry_pkg::ST_W-1:0] next_status;
   logic                          next_pend_short;
   logic                          next_pend_err;

   assign next_pend_short = ~I_FRAME_END & (pend_short | short_hit);
   assign next_pend_err   = ~I_FRAME_END & (pend_err | irq_err);
   assign st_set = I_FRAME_END ? {pend_err | irq_err, pend_short | short_hit}
                               : {td_retry_pkg::ST_W{1'b0}};
   // a set in the clearing cycle survives the read
   // only bits the read returned are cleared, so a set at the setup edge is kept
   assign next_status = (rd_status ? status & ~O_PRDATA[td_retry_pkg::ST_W-1:0] : status)
                      | st_set;

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         pend_short        <= 1'b0;
         pend_err          <= 1'b0;
         status            <= td_retry_pkg::STATUS_RESET;
         O_XFER_INT_STATUS <= 1'b0;
         O_IRQ             <= 1'b0;
      end else begin
         pend_short        <= next_pend_short;
         pend_err          <= next_pend_err;
         status            <= next_status;
         O_XFER_INT_STATUS <= |next_status;
         O_IRQ             <= |(next_status & next_mask);
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);

   short_inact_a: assert property (short_hit |=> O_WB_VALID
         && !O_WB_WORD[td_retry_pkg::ACTIVE_BIT] && O_QH_KEEP)
      else $error("short packet did not deactivate descriptor");

   short_err_a: assert property (I_TXN_DONE && any_err |=> !O_QH_KEEP)
      else $error("short packet reported despite error");

   short_eof_a: assert property (short_hit ##1 !I_FRAME_END [*2] ##1 I_FRAME_END
         |=> status[td_retry_pkg::ST_SHORT])
      else $error("short packet status not set at frame end");

   irq_mask_a: assert property (O_IRQ == |(status & mask))
      else $error("interrupt line disagrees with status and mask");

   xis_level_a: assert property (O_XFER_INT_STATUS == |status)
      else $error("transfer interrupt status disagrees with status");

   rd_clear_a: assert property (rd_status && !I_FRAME_END
         |=> (status & $past(O_PRDATA[td_retry_pkg::ST_W-1:0])) == '0)
      else $error("status read did not clear");

   pend_clear_a: assert property (I_FRAME_END |=> !pend_short && !pend_err)
      else $error("pending event survived frame end");

   pready_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("access phase without ready");

   slverr_a: assert property (O_PSLVERR |-> O_PREADY)
      else $error("error response without ready");

   cerr_dec_a: assert property (dec |=> O_WB_WORD[td_retry_pkg::CERR_HI:td_retry_pkg::CERR_LO]
         == $past(cerr) - 2'h1)
      else $error("error counter not decremented");

   wb_pulse_a: assert property (I_TXN_DONE |=> O_WB_VALID)
      else $error("write-back did not follow transaction");

   wb_hold_a: assert property (!I_TXN_DONE |=> $stable(O_WB_WORD) && !O_WB_VALID)
      else $error("write-back word moved without transaction");

   qh_pulse_a: assert property (O_QH_KEEP |-> O_WB_VALID)
      else $error("queue head hold without write-back");

   short_idle_a: assert property (!I_TXN_DONE |=> !O_QH_KEEP)
      else $error("queue head hold without transaction");

   cerr_keep_a: assert property (I_TXN_DONE && !count_err |=>
         O_WB_WORD[td_retry_pkg::CERR_HI:td_retry_pkg::CERR_LO] == $past(cerr))
      else $error("error counter changed on success");

   nolimit_a: assert property (I_TXN_DONE && cerr == 2'h0 && !I_ERR_BABBLE
         && !I_ERR_STALL && !short_hit |=> O_WB_WORD[td_retry_pkg::ACTIVE_BIT]
         == $past(I_TD_WORD[td_retry_pkg::ACTIVE_BIT]))
      else $error("unlimited descriptor was retired");

   nolimit_cnt_a: assert property (I_TXN_DONE && cerr == td_retry_pkg::CERR_NO_LIMIT
         |=> O_WB_WORD[td_retry_pkg::CERR_HI:td_retry_pkg::CERR_LO] == 2'h0)
      else $error("unlimited counter was decremented");

   babble_retire_a: assert property (I_TXN_DONE && I_ERR_BABBLE
         |=> !O_WB_WORD[td_retry_pkg::ACTIVE_BIT] && O_WB_WORD[td_retry_pkg::STALL_BIT])
      else $error("babble did not retire descriptor");

   limit_stall_a: assert property (to_zero |=> !O_WB_WORD[td_retry_pkg::ACTIVE_BIT]
         && O_WB_WORD[td_retry_pkg::STALL_BIT])
      else $error("limit reached without stall");

   limit_pend_a: assert property (to_zero && (I_ERR_DBUF || I_ERR_BSTUFF)
         && !I_FRAME_END |=> pend_err)
      else $error("buffer or bit stuff limit not pending");

   limit_irq_a: assert property (to_zero && I_ERR_DBUF ##1 !I_FRAME_END [*2]
         ##1 I_FRAME_END |=> status[td_retry_pkg::ST_ERRLIM])
      else $error("buffer error limit did not flag");

   two_err_a: assert property (dec && cerr == 2'h2 && !I_ERR_BABBLE && !I_ERR_STALL
         |=> O_WB_WORD[td_retry_pkg::ACTIVE_BIT] == $past(I_TD_WORD[td_retry_pkg::ACTIVE_BIT]))
      else $error("two-error limit retired early");

endmodule

// ### usb_dev_model.sv
`timescale 1ns/1ns
module usb_dev_model (
   input  wire logic       i_clk,
   input  wire logic       i_start,
   input  wire logic [2:0] i_code,
   input  wire logic       i_short,
   output logic            o_done,
   output logic            o_short,
   output logic [5:0]      o_err
);
   // codes 1..6: crc, timeout, buffer, bit stuff, babble, stall
   // idle result lines toggle so a stale result never looks valid
   always_ff @(posedge i_clk) begin
      o_done  <= i_start;
      o_short <= i_start ? i_short : ~o_short;
      o_err   <= i_start ? ((i_code == 3'h0) ? 6'h00 : 6'h01 << (i_code - 3'h1)) : ~o_err;
   end
endmodule

// ### usb_td_error_retry_short_packet_tb.sv
`timescale 1ns/1ns
module usb_td_error_retry_short_packet_tb;
   logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [3:0]  paddr = 4'h0;
   logic [31:0] pwd = 32'h0, word = 32'h0, rd, prdata, wbw;
   logic        start = 1'b0, shrt = 1'b0, tin = 1'b0, tq = 1'b0, fe = 1'b0;
   logic [2:0]  code = 3'h0;
   logic        done, tshort, pready, pslverr, wbv, qhk, xis, irq, err_b;
   logic [5:0]  err;
   logic [1:0]  mask, ctrl;
   int          seed = 6270, failures = 0, cmp_count = 0;

   always #5 clk = ~clk;

   usb_dev_model u_usb_dev_model (.i_clk(clk), .i_start(start), .i_code(code),
      .i_short(shrt), .o_done(done), .o_short(tshort), .o_err(err));
   td_retry u_td_retry (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_TXN_DONE(done), .I_TD_WORD(word),
      .I_TXN_IN(tin), .I_TXN_QUEUED(tq), .I_TXN_SHORT(tshort), .I_ERR_CRC(err[0]),
      .I_ERR_TIMEOUT(err[1]), .I_ERR_DBUF(err[2]), .I_ERR_BSTUFF(err[3]),
      .I_ERR_BABBLE(err[4]), .I_ERR_STALL(err[5]), .I_FRAME_END(fe), .O_WB_VALID(wbv),
      .O_WB_WORD(wbw), .O_QH_KEEP(qhk), .O_XFER_INT_STATUS(xis), .O_IRQ(irq));

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      psel  <= 1'b1;
      pen   <= 1'b0;
      pwr   <= w;
      paddr <= a;
      pwd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd    = prdata;
      err_b = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask

   // returns {limit event, short event, written-back word}
   function automatic logic [33:0] f_exp(input logic [31:0] w, input logic [2:0] c,
         input logic s, input logic pq, input logic [1:0] cr);
      logic [31:0] r;
      logic        sh;
      logic        lim;
      r   = w;
      sh  = 1'b0;
      lim = 1'b0;
      if (c >= 3'h5) begin
         r[td_retry_pkg::ACTIVE_BIT] = 1'b0;
         r[td_retry_pkg::STALL_BIT] = 1'b1;
         if (c == 3'h5)
            r[td_retry_pkg::BABBLE_BIT] = 1'b1;
      end else if (c != 3'h0 && w[28:27] != 2'h0) begin
         r[28:27] = w[28:27] - 2'h1;
         if (w[28:27] == 2'h1) begin
            r[td_retry_pkg::ACTIVE_BIT] = 1'b0;
            r[td_retry_pkg::STALL_BIT]  = 1'b1;
            r[(c == 3'h3) ? td_retry_pkg::DBUF_BIT : (c == 3'h4) ? td_retry_pkg::BSTUFF_BIT
               : td_retry_pkg::CRCTO_BIT] = 1'b1;
            lim = (c > 3'h2) || cr[c[0] ? 0 : 1];
         end
      end else if (c == 3'h0 && s && w[29] && pq) begin
         r[td_retry_pkg::ACTIVE_BIT] = 1'b0;
         sh = 1'b1;
      end
      return {lim, sh, r};
   endfunction

   initial begin
      #200000;
      failures++;
      complete_run();
   end

   initial begin
      logic [33:0] e;
      logic [31:0] w;
      logic [2:0]  c;
      logic        s, pi, pq;
      int          n;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, td_retry_pkg::MASK_ADDR, 32'h0);
      chk(rd, {30'h0, td_retry_pkg::MASK_RESET});
      apb(1'b0, 4'h2, 32'h0);
      chk({31'h0, err_b}, 32'h1);
      for (int i = 0; i < 60; i++) begin
         if (i == 30) begin
            rstn <= 1'b0;
            @(posedge clk);
            chk({28'h0, wbv, qhk, xis, irq}, 32'h0);
            rstn <= 1'b1;
            apb(1'b0, td_retry_pkg::CTRL_ADDR, 32'h0);
            chk(rd, {30'h0, td_retry_pkg::CTRL_RESET});
         end
         mask = 2'($random(seed));
         ctrl = 2'($random(seed));
         apb(1'b1, td_retry_pkg::MASK_ADDR, {30'h0, mask});
         apb(1'b1, td_retry_pkg::CTRL_ADDR, {30'h0, ctrl});
         apb(1'b0, td_retry_pkg::CTRL_ADDR, 32'h0);
         chk(rd, {30'h0, ctrl});
         // first passes: each result code on a counter about to expire
         c  = (i < 7) ? 3'(i) : 3'($unsigned($random(seed)) % 7);
         w  = $random(seed);
         pi = 1'($random(seed));
         pq = 1'($random(seed));
         s  = 1'($random(seed));
         w[td_retry_pkg::ACTIVE_BIT] = 1'b1;
         if (i < 7)
            w[28:27] = 2'h1;
         w[29] = w[29] & pi & pq;
         e = f_exp(w, c, s, pi & pq, ctrl);
         @(posedge clk);
         start <= 1'b1;
         code  <= c;
         shrt  <= s;
         word  <= w;
         tin   <= pi;
         tq    <= pq;
         @(posedge clk);
         start <= 1'b0;
         n = 0;
         do
            @(posedge clk);
         while (wbv !== 1'b1 && ++n < 10);
         chk({31'h0, wbv}, 32'h1);
         chk(wbw, e[31:0]);
         chk({31'h0, qhk}, {31'h0, e[32]});
         chk({31'h0, xis}, 32'h0);
         @(posedge clk);
         fe <= 1'b1;
         @(posedge clk);
         fe <= 1'b0;
         @(posedge clk);
         chk({30'h0, xis, irq}, {30'h0, |e[33:32], |(e[33:32] & mask)});
         apb(1'b0, td_retry_pkg::STATUS_ADDR, 32'h0);
         chk(rd, {30'h0, e[33:32]});
         apb(1'b0, td_retry_pkg::LASTWB_ADDR, 32'h0);
         chk(rd, e[31:0]);
         chk({31'h0, xis}, 32'h0);
      end
      complete_run();
   end
endmodule
